// ===== include/bcr_cfg.svh
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
`define BCR_OFS_SETPT1    6'h00
`define BCR_OFS_SETPT2    6'h01
`define BCR_OFS_CTRL      6'h02
`define BCR_OFS_MODE      6'h03
`define BCR_OFS_LOAD_DAC_STROBE      6'h04
`define BCR_OFS_MSGREQ    6'h05
`define BCR_OFS_FIFO      6'h06
`define BCR_OFS_PARAM     6'h07
`define BCR_OFS_DACIN1    6'h08
`define BCR_OFS_DACIN2    6'h09
`define BCR_OFS_DACIO1    6'h0a
`define BCR_OFS_DACIO2    6'h0b
`define BCR_OFS_STATUS    6'h0c
`define BCR_CTRL_OSC_POWERDOWN    0
`define BCR_CTRL_PD1      1
`define BCR_CTRL_PD2      2
`define BCR_CTRL_SRC_LO   3
`define BCR_CTRL_SRC_HI   4
`define BCR_LOAD_DAC_STROBE_CH1      0
`define BCR_LOAD_DAC_STROBE_CH2      1
`define BCR_MR_LEN_LO     0
`define BCR_MR_LEN_HI     7
`define BCR_MR_ADR_LO     8
`define BCR_MR_ADR_HI     15
`define BCR_PAR_TH_LO     12
`define BCR_PAR_TH_HI     15
`define BCR_PAR_WGT       7
`define BCR_PAR_LIM_LO    4
`define BCR_PAR_LIM_HI    6
`define BCR_PAR_AH_LO     0
`define BCR_PAR_AH_HI     3
`define BCR_RST_12        12'h000
`define BCR_RST_4         4'h0
`define BCR_FIFO_DEPTH    4'h8
`define BCR_MON_DEPTH     4'h7
`define BCR_CLK_NS        10
`define BCR_ALM_PULSE_NS  100
`define BCR_ALM_PULSE_CYC (`BCR_ALM_PULSE_NS / `BCR_CLK_NS)
`endif

// ===== include/bcr_pkg.sv
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_IDLE,
    BCR_MSG,
    BCR_MON,
    BCR_LUT
  } bcr_mode_t;
endpackage : bcr_pkg

// ===== core/bcr_core.sv
`timescale 1ns/10ps
// Contract
// RULE_01 - Oscillator power-down bit set suspends every internal operation; streaming FIFO writes and returning memory words are still accepted here.
// RULE_02 - Oscillator power-down bit clears itself on the next command.
// RULE_03 - Watchdog overflow resets the device and pulses the alarm output.
// RULE_04 - DAC power-down bit powers channel down; DAC writes still accepted.
// RULE_05 - Load strobe copies DAC input to output per channel bit.
// RULE_06 - Load strobe stores nothing; bits 15 to 2 are ignored.
// RULE_07 - Message request enters message mode; length field is words minus one.
// RULE_08 - Message start field gives first memory address of sequential read.
// RULE_09 - Message FIFO is read-only, eight deep, stalls memory reads when full.
// RULE_10 - Monitor entries carry 12-bit result and 4-bit channel tag.
// RULE_11 - Monitor FIFO keeps seven newest results; oldest read first.
// RULE_12 - Streaming FIFO is write-only, eight deep, words go to memory.
// RULE_13 - Streaming write into full FIFO is discarded silently.
// RULE_14 - Source select 00: hysteresis code 15:12, parameter value 11:0.
// RULE_15 - Source select 1x: hysteresis, weight bit 7, limit 6:4, hysteresis 3:0.
// RULE_16 - Weight bit 0 adds difference/16, 1 adds difference/4.
// RULE_17 - Temperature hysteresis band is code plus one LSBs.
// RULE_18 - Parameter hysteresis band is code plus one LSBs.
// RULE_19 - Host clears compensation enables before changing hysteresis codes.
// RULE_20 - Setpoint holds 12 bits; bits 15:12 read zero.
// RULE_21 - Difference limit caps each averaging step at 2^code minus one; code 0 leaves the step uncapped here.
`include "bcr_cfg.svh"
module bcr_core (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        reg_stb,
  input  wire logic        reg_wr,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        wdog_ovf,
  output logic             alarm_pulse,
  output logic             osc_run,
  output logic      [1:0]  chan_dac_powerdown,
  output logic      [11:0] dac_out_ch1,
  output logic      [11:0] dac_out_ch2,
  output logic      [11:0] gate_setpoint_ch1,
  output logic      [11:0] gate_setpoint_ch2,
  input  wire logic        mon_valid,
  input  wire logic [11:0] mon_data,
  input  wire logic [3:0]  mon_tag,
  output logic             nvm_rd_valid,
  input  wire logic        nvm_rd_ready,
  output logic      [7:0]  nvm_rd_addr,
  input  wire logic        nvm_rdata_valid,
  output logic             nvm_rdata_ready,
  input  wire logic [15:0] nvm_rdata,
  output logic             nvm_wr_valid,
  input  wire logic        nvm_wr_ready,
  output logic      [7:0]  nvm_wr_addr,
  output logic      [15:0] nvm_wr_data,
  input  wire logic        avg_in_valid,
  input  wire logic        avg_in_ch,
  input  wire logic [11:0] avg_in_data,
  output logic      [11:0] param_avg_ch1,
  output logic      [11:0] param_avg_ch2,
  output logic      [4:0]  temp_hyst_lsb,
  output logic      [4:0]  param_hyst_lsb
);
  function automatic logic [12:0] avg_step(input logic [11:0] s,
    input logic [11:0] a, input logic w, input logic [2:0] lim);
    logic signed [12:0] d;
    logic signed [12:0] st;
    logic signed [12:0] cap;
    d   = $signed({1'b0, s}) - $signed({1'b0, a});
    st  = w ? (d >>> 2) : (d >>> 4);
    cap = (13'sd1 <<< lim) - 13'sd1;
    if (lim != 3'h0 && st > cap)
      st = cap;
    if (lim != 3'h0 && st < -cap)
      st = -cap;
    return st;
  endfunction : avg_step

  function automatic logic [4:0] band(input logic [3:0] code);
    return {1'b0, code} + 5'h01;
  endfunction : band

  logic wd_s1_r, wd_s2_r, wd_s3_r;
  logic [3:0] alm_cnt_r;
  logic osc_pd_r;
  logic [1:0] chan_dac_powerdown_r;
  logic [1:0] src_r;
  logic [11:0] setpt_r [2];
  logic [11:0] dac_in_r [2];
  logic [11:0] dac_o_r [2];
  logic [3:0] thist_r, ahist_r;
  logic [11:0] pval_r;
  logic wgt_r;
  logic [2:0] lim_r;
  bcr_pkg::bcr_mode_t mode_r;
  logic [7:0] lut_addr_r;
  logic [8:0] msg_left_r;
  logic [7:0] msg_addr_r;
  logic msg_wait_r;
  logic [15:0] fmem_r [8];
  logic [2:0] fwp_r, frp_r;
  logic [3:0] fcnt_r;
  logic [15:0] bmem_r [2];
  logic bwp_r, brp_r;
  logic [1:0] bcnt_r;
  logic [11:0] avg_r [2];
  logic [11:0] held_r [2];
  logic [15:0] rdata_r;
  logic rvalid_r;

  wire soft_rst = wd_s2_r & ~wd_s3_r;
  wire run = ~osc_pd_r; // RULE_01
  wire wr  = reg_stb & reg_wr;
  wire rd  = reg_stb & ~reg_wr;
  wire wr_ctrl = wr && reg_addr == `BCR_OFS_CTRL;
  wire wr_mode = wr && reg_addr == `BCR_OFS_MODE;
  wire wr_load_dac_strobe = wr && reg_addr == `BCR_OFS_LOAD_DAC_STROBE;
  wire wr_mr   = wr && reg_addr == `BCR_OFS_MSGREQ;
  wire wr_fifo = wr && reg_addr == `BCR_OFS_FIFO;
  wire wr_par  = wr && reg_addr == `BCR_OFS_PARAM;
  wire rd_fifo = rd && reg_addr == `BCR_OFS_FIFO;
  wire is_msg = mode_r == bcr_pkg::BCR_MSG;
  wire is_mon = mode_r == bcr_pkg::BCR_MON;
  wire is_lut = mode_r == bcr_pkg::BCR_LUT;
  wire mode_chg = wr_mode | wr_mr;

  // Message words pass a two-entry buffer so a full FIFO back-pressures
  // the memory instead of dropping a returning word.
  wire buf_in  = nvm_rdata_valid & nvm_rdata_ready;
  wire buf_out = bcnt_r != 2'h0 && is_msg && fcnt_r < `BCR_FIFO_DEPTH
                 && run; // RULE_09
  wire host_pop = rd_fifo && (is_msg || is_mon) && fcnt_r != 4'h0;
  wire mon_push = is_mon & mon_valid & run; // RULE_10
  wire mon_drop = mon_push && fcnt_r == `BCR_MON_DEPTH && !host_pop; // RULE_11
  wire lut_push = wr_fifo && is_lut && fcnt_r < `BCR_FIFO_DEPTH; // RULE_13
  wire nvm_pop = nvm_wr_valid & nvm_wr_ready;
  wire push = buf_out | mon_push | lut_push;
  wire pop = host_pop | mon_drop | nvm_pop;
  wire [15:0] push_data = mon_push ? {mon_tag, mon_data} :
                          lut_push ? reg_wdata : bmem_r[brp_r];
  wire nvm_req = nvm_rd_valid & nvm_rd_ready;
  wire [12:0] avg_d = avg_step(avg_in_data, avg_r[avg_in_ch], wgt_r,
    lim_r); // RULE_16 RULE_21
  wire [11:0] avg_new = avg_r[avg_in_ch] + avg_d[11:0];
  wire [11:0] held_cur = held_r[avg_in_ch];
  wire [11:0] hdiff = avg_new > held_cur ? avg_new - held_cur
                                         : held_cur - avg_new;
  wire hyst_pass = {1'b0, hdiff} >= {8'h00, band(ahist_r)}; // RULE_18
  wire [15:0] par_rd = src_r[1] ? {thist_r, 4'h0, wgt_r, lim_r, ahist_r}
                                : {thist_r, pval_r}; // RULE_15 RULE_14
  wire [15:0] fifo_rd = fcnt_r != 4'h0 ? fmem_r[frp_r] : 16'h0000;
  wire [15:0] rd_mux =
    reg_addr == `BCR_OFS_SETPT1 ? {4'h0, setpt_r[0]} : // RULE_20
    reg_addr == `BCR_OFS_SETPT2 ? {4'h0, setpt_r[1]} :
    reg_addr == `BCR_OFS_CTRL ? {11'h000, src_r, chan_dac_powerdown_r, osc_pd_r} :
    reg_addr == `BCR_OFS_MODE ? {lut_addr_r, 6'h00, mode_r} :
    reg_addr == `BCR_OFS_FIFO && (is_msg || is_mon) ? fifo_rd :
    reg_addr == `BCR_OFS_PARAM ? par_rd :
    reg_addr == `BCR_OFS_DACIN1 ? {4'h0, dac_in_r[0]} :
    reg_addr == `BCR_OFS_DACIN2 ? {4'h0, dac_in_r[1]} :
    reg_addr == `BCR_OFS_DACIO1 ? {4'h0, dac_o_r[0]} :
    reg_addr == `BCR_OFS_DACIO2 ? {4'h0, dac_o_r[1]} :
    reg_addr == `BCR_OFS_STATUS ? {3'h0, msg_left_r, 1'b0, bcnt_r,
                                   msg_wait_r} :
    16'h0000;

  assign osc_run = run;
  assign alarm_pulse = alm_cnt_r != 4'h0;
  assign chan_dac_powerdown = chan_dac_powerdown_r; // RULE_04
  assign dac_out_ch1 = dac_o_r[0];
  assign dac_out_ch2 = dac_o_r[1];
  assign gate_setpoint_ch1 = setpt_r[0];
  assign gate_setpoint_ch2 = setpt_r[1];
  assign nvm_rd_valid = is_msg && msg_left_r != 9'h000 && !msg_wait_r
                        && run; // RULE_01
  assign nvm_rd_addr = msg_addr_r;
  assign nvm_rdata_ready = bcnt_r != 2'h2;
  assign nvm_wr_valid = is_lut && fcnt_r != 4'h0 && run; // RULE_12
  assign nvm_wr_addr = lut_addr_r;
  assign nvm_wr_data = fmem_r[frp_r];
  assign param_avg_ch1 = held_r[0];
  assign param_avg_ch2 = held_r[1];
  assign temp_hyst_lsb = band(thist_r); // RULE_17
  assign param_hyst_lsb = band(ahist_r);
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // The first synchroniser stage feeds only the second one.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wd_s1_r <= 1'b0;
      wd_s2_r <= 1'b0;
      wd_s3_r <= 1'b0;
      alm_cnt_r <= 4'h0;
    end
    else
    begin
      wd_s1_r <= wdog_ovf;
      wd_s2_r <= wd_s1_r;
      wd_s3_r <= wd_s2_r;
      if (soft_rst)
        alm_cnt_r <= 4'(`BCR_ALM_PULSE_CYC); // RULE_03
      else if (alm_cnt_r != 4'h0)
        alm_cnt_r <= alm_cnt_r - 4'h1;
    end
  end

  // Control and parameter registers; the serial port keeps working while
  // the oscillator is down, so these ignore the suspend.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b || soft_rst) // RULE_03
    begin
      osc_pd_r <= 1'b0;
      chan_dac_powerdown_r <= 2'h0;
      src_r <= 2'h0;
      setpt_r <= '{`BCR_RST_12, `BCR_RST_12};
      dac_in_r <= '{`BCR_RST_12, `BCR_RST_12};
      dac_o_r <= '{`BCR_RST_12, `BCR_RST_12};
      thist_r <= `BCR_RST_4;
      ahist_r <= `BCR_RST_4;
      pval_r <= `BCR_RST_12;
      wgt_r <= 1'b0;
      lim_r <= 3'h0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= rd;
      if (rd)
        rdata_r <= rd_mux;
      if (wr_ctrl)
      begin
        osc_pd_r <= reg_wdata[`BCR_CTRL_OSC_POWERDOWN];
        chan_dac_powerdown_r <= {reg_wdata[`BCR_CTRL_PD2], reg_wdata[`BCR_CTRL_PD1]};
        src_r <= reg_wdata[`BCR_CTRL_SRC_HI:`BCR_CTRL_SRC_LO];
      end
      else if (reg_stb)
        osc_pd_r <= 1'b0; // RULE_02
      if (wr && reg_addr == `BCR_OFS_SETPT1)
        setpt_r[0] <= reg_wdata[11:0]; // RULE_20
      if (wr && reg_addr == `BCR_OFS_SETPT2)
        setpt_r[1] <= reg_wdata[11:0];
      for (int c = 0; c < 2; c++)
      begin
        if (wr && reg_addr == `BCR_OFS_DACIN1 + 6'(c))
          dac_in_r[c] <= reg_wdata[11:0]; // RULE_04
        if (wr && reg_addr == `BCR_OFS_DACIO1 + 6'(c))
        begin
          dac_in_r[c] <= reg_wdata[11:0];
          dac_o_r[c] <= reg_wdata[11:0];
        end
        else if (wr_load_dac_strobe && reg_wdata[`BCR_LOAD_DAC_STROBE_CH1 + c])
          dac_o_r[c] <= dac_in_r[c]; // RULE_05 RULE_06
      end
      if (wr_par)
      begin
        thist_r <= reg_wdata[`BCR_PAR_TH_HI:`BCR_PAR_TH_LO];
        if (!src_r[1])
          pval_r <= reg_wdata[11:0]; // RULE_14
        if (src_r[1])
        begin
          wgt_r <= reg_wdata[`BCR_PAR_WGT]; // RULE_15
          lim_r <= reg_wdata[`BCR_PAR_LIM_HI:`BCR_PAR_LIM_LO];
          ahist_r <= reg_wdata[`BCR_PAR_AH_HI:`BCR_PAR_AH_LO];
        end
      end
    end
  end

  // Mode, message sequencer and buffers. Any mode change flushes both
  // queues so stale words of one mode never leak into another.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b || soft_rst)
    begin
      mode_r <= bcr_pkg::BCR_IDLE;
      lut_addr_r <= 8'h00;
      msg_left_r <= 9'h000;
      msg_addr_r <= 8'h00;
      msg_wait_r <= 1'b0;
      fwp_r <= 3'h0;
      frp_r <= 3'h0;
      fcnt_r <= 4'h0;
      bwp_r <= 1'b0;
      brp_r <= 1'b0;
      bcnt_r <= 2'h0;
    end
    else if (mode_chg)
    begin
      fwp_r <= 3'h0;
      frp_r <= 3'h0;
      fcnt_r <= 4'h0;
      bwp_r <= 1'b0;
      brp_r <= 1'b0;
      bcnt_r <= 2'h0;
      msg_wait_r <= 1'b0;
      if (wr_mr)
      begin
        mode_r <= bcr_pkg::BCR_MSG; // RULE_07
        msg_left_r <= {1'b0, reg_wdata[`BCR_MR_LEN_HI:`BCR_MR_LEN_LO]}
                      + 9'h001;
        msg_addr_r <= reg_wdata[`BCR_MR_ADR_HI:`BCR_MR_ADR_LO]; // RULE_08
      end
      else
      begin
        mode_r <= bcr_pkg::bcr_mode_t'(reg_wdata[1:0]);
        lut_addr_r <= reg_wdata[15:8];
        msg_left_r <= 9'h000;
      end
    end
    else
    begin
      if (nvm_req)
      begin
        msg_addr_r <= msg_addr_r + 8'h01; // RULE_08
        msg_left_r <= msg_left_r - 9'h001;
        msg_wait_r <= 1'b1;
      end
      else if (buf_in)
        msg_wait_r <= 1'b0;
      if (buf_in)
      begin
        bwp_r <= ~bwp_r;
        bmem_r[bwp_r] <= nvm_rdata;
      end
      if (buf_out)
        brp_r <= ~brp_r;
      bcnt_r <= bcnt_r + {1'b0, buf_in} - {1'b0, buf_out};
      if (push)
      begin
        fmem_r[fwp_r] <= push_data;
        fwp_r <= fwp_r + 3'h1;
      end
      if (pop)
        frp_r <= frp_r + 3'h1;
      fcnt_r <= fcnt_r + {3'h0, push} - {3'h0, pop};
      if (nvm_pop)
        lut_addr_r <= lut_addr_r + 8'h01; // RULE_12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b || soft_rst)
    begin
      avg_r <= '{`BCR_RST_12, `BCR_RST_12};
      held_r <= '{`BCR_RST_12, `BCR_RST_12};
    end
    else if (avg_in_valid && run)
    begin
      avg_r[avg_in_ch] <= avg_new; // RULE_16
      if (hyst_pass)
        held_r[avg_in_ch] <= avg_new; // RULE_18
    end
  end

  a_osc_autoclr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    osc_pd_r && reg_stb && !wr_ctrl && !soft_rst |=> !osc_pd_r) // RULE_02
    else $error("oscillator power-down did not clear on command");
  a_suspend_io: assert property (@(posedge ref_clk) disable iff (!rst_b)
    osc_pd_r |-> !nvm_rd_valid && !nvm_wr_valid && !buf_out) // RULE_01
    else $error("memory traffic while oscillator is down");
  a_load_dac_strobe_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_load_dac_strobe && reg_wdata[0] && !soft_rst
    && !(wr && reg_addr == `BCR_OFS_DACIO1)
    |=> dac_o_r[0] == $past(dac_in_r[0])) // RULE_05
    else $error("load strobe did not move channel 1 value");
  a_load_dac_strobe_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_load_dac_strobe && reg_wdata[1:0] == 2'h0 && !soft_rst
    |=> $stable(dac_o_r[0]) && $stable(dac_o_r[1])) // RULE_06
    else $error("load strobe changed an output without its bit");
  a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fcnt_r <= `BCR_FIFO_DEPTH && (!is_mon || fcnt_r <= `BCR_MON_DEPTH))
    else $error("FIFO holds more than its depth"); // RULE_09
  a_mon_keep7: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mon_drop && !mode_chg && !soft_rst |=> fcnt_r == `BCR_MON_DEPTH)
    else $error("monitor FIFO lost its seven newest"); // RULE_11
  a_lut_discard: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_fifo && is_lut && fcnt_r == `BCR_FIFO_DEPTH && !nvm_pop
    && !soft_rst |=> fcnt_r == `BCR_FIFO_DEPTH && $stable(fwp_r))
    else $error("write into full streaming FIFO was kept"); // RULE_13
  a_alarm_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    soft_rst |=> alarm_pulse [*8] ##1 alarm_pulse [*2] ##1 !alarm_pulse)
    else $error("watchdog alarm pulse has wrong length"); // RULE_03
  a_msg_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_mr && !soft_rst
    |=> msg_left_r == {1'b0, $past(reg_wdata[7:0])} + 9'h001) // RULE_07
    else $error("message length is not field plus one");
endmodule : bcr_core

// ===== testbench/bcr_nvm_model.sv
`timescale 1ns/10ps
module bcr_nvm_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        hold,
  input  wire logic        nvm_rd_valid,
  output logic             nvm_rd_ready,
  input  wire logic [7:0]  nvm_rd_addr,
  output logic             nvm_rdata_valid,
  input  wire logic        nvm_rdata_ready,
  output logic      [15:0] nvm_rdata,
  input  wire logic        nvm_wr_valid,
  output logic             nvm_wr_ready,
  input  wire logic [7:0]  nvm_wr_addr,
  input  wire logic [15:0] nvm_wr_data
);
  logic [15:0] mem [256];
  logic        pend_r = 1'b0;
  logic        stall_r = 1'b0;
  logic [7:0]  addr_r = 8'h00;
  // Random stalls make the device prove that it holds its requests.
  assign nvm_rd_ready = !pend_r && !stall_r && !hold;
  assign nvm_wr_ready = !stall_r && !hold;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {8'(i) ^ 8'h5a, 8'(i)};
  end
  always @(posedge ref_clk or negedge rst_b)
  begin
    stall_r <= 1'($urandom_range(0, 1));
    if (!rst_b)
    begin
      pend_r <= 1'b0;
      nvm_rdata_valid <= 1'b0;
      nvm_rdata <= 16'hffff;
    end
    else
    begin
      if (nvm_rd_valid && nvm_rd_ready)
      begin
        pend_r <= 1'b1;
        addr_r <= nvm_rd_addr;
      end
      if (pend_r && !nvm_rdata_valid && !stall_r)
      begin
        nvm_rdata_valid <= 1'b1;
        nvm_rdata <= mem[addr_r];
      end
      // A released data bus shows the inverse of its last word.
      if (nvm_rdata_valid && nvm_rdata_ready)
      begin
        nvm_rdata_valid <= 1'b0;
        pend_r <= 1'b0;
        nvm_rdata <= ~nvm_rdata;
      end
      if (nvm_wr_valid && nvm_wr_ready)
        mem[nvm_wr_addr] <= nvm_wr_data;
    end
  end
endmodule : bcr_nvm_model

// ===== testbench/tb.sv
`timescale 1ns/10ps
`include "bcr_cfg.svh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_stb = 1'b0;
  logic        reg_wr = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        wdog_ovf = 1'b0;
  logic        mon_valid = 1'b0;
  logic [11:0] mon_data = 12'h000;
  logic [3:0]  mon_tag = 4'h0;
  logic        avg_in_valid = 1'b0;
  logic        avg_in_ch = 1'b0;
  logic [11:0] avg_in_data = 12'h000;
  logic        hold = 1'b0;
  logic [15:0] reg_rdata, nvm_rdata, nvm_wr_data, v, g;
  logic [11:0] dac_out_ch1, dac_out_ch2, gate_setpoint_ch1;
  logic [11:0] gate_setpoint_ch2, param_avg_ch1, param_avg_ch2;
  logic [7:0]  nvm_rd_addr, nvm_wr_addr;
  logic [4:0]  temp_hyst_lsb, param_hyst_lsb;
  logic [1:0]  chan_dac_powerdown;
  logic        reg_rvalid, alarm_pulse, osc_run, nvm_rd_valid;
  logic        nvm_rd_ready, nvm_rdata_valid, nvm_rdata_ready;
  logic        nvm_wr_valid, nvm_wr_ready;
  logic [15:0] sh [256];
  logic [15:0] q [10];
  logic [11:0] av [2] = '{12'h000, 12'h000};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          n;

  bcr_core i_dut (.ref_clk, .rst_b, .reg_stb, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .wdog_ovf, .alarm_pulse, .osc_run,
    .chan_dac_powerdown, .dac_out_ch1, .dac_out_ch2, .gate_setpoint_ch1,
    .gate_setpoint_ch2, .mon_valid, .mon_data, .mon_tag, .nvm_rd_valid,
    .nvm_rd_ready, .nvm_rd_addr, .nvm_rdata_valid, .nvm_rdata_ready,
    .nvm_rdata, .nvm_wr_valid, .nvm_wr_ready, .nvm_wr_addr, .nvm_wr_data,
    .avg_in_valid, .avg_in_ch, .avg_in_data, .param_avg_ch1, .param_avg_ch2,
    .temp_hyst_lsb, .param_hyst_lsb);
  bcr_nvm_model i_nvm (.ref_clk, .rst_b, .hold, .nvm_rd_valid,
    .nvm_rd_ready, .nvm_rd_addr, .nvm_rdata_valid, .nvm_rdata_ready,
    .nvm_rdata, .nvm_wr_valid, .nvm_wr_ready, .nvm_wr_addr, .nvm_wr_data);

  always #5 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_stb = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_stb = 1'b0;
  endtask : wr

  // The answer stands for one cycle only, so it is taken at once.
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    reg_stb = 1'b1;
    reg_wr = 1'b0;
    reg_addr = a;
    @(negedge ref_clk);
    reg_stb = 1'b0;
    chk(16'(reg_rvalid), 16'h0001);
    chk(reg_rdata, e);
  endtask : rchk

  task automatic pulse_mon(input logic [15:0] e);
    @(negedge ref_clk);
    mon_valid = 1'b1;
    mon_tag = e[15:12];
    mon_data = e[11:0];
    @(negedge ref_clk);
    mon_valid = 1'b0;
  endtask : pulse_mon

  task automatic msg(input logic [7:0] s, input logic [7:0] l);
    wr(`BCR_OFS_MSGREQ, {s, l});
    cyc(100);
    v = {13'h0000, (l > 8'h07 ? 2'(l - 8'h07) : 2'h0), 1'b0};
    rchk(`BCR_OFS_STATUS, v);
    for (int k = 0; k <= int'(l); k++)
    begin
      rchk(`BCR_OFS_FIFO, sh[8'(int'(s) + k)]);
      cyc(12);
    end
    rchk(`BCR_OFS_FIFO, 16'h0000);
  endtask : msg

  function automatic logic [11:0] nxt(input logic [11:0] a,
    input logic [11:0] s, input logic w, input logic [2:0] lim);
    logic signed [12:0] d;
    logic signed [12:0] c;
    d = $signed({1'b0, s}) - $signed({1'b0, a});
    d = w ? d >>> 2 : d >>> 4;
    c = (13'sh1 <<< lim) - 13'sh1;
    if (lim != 3'h0 && d > c)
      d = c;
    if (lim != 3'h0 && d < -c)
      d = -c;
    return a + 12'(d);
  endfunction : nxt

  initial
  begin
    #300000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'hcb25));
    for (int i = 0; i < 256; i++)
      sh[i] = {8'(i) ^ 8'h5a, 8'(i)};
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    chk(16'(osc_run), 16'h0001);
    rchk(`BCR_OFS_PARAM, 16'h0000);
    rchk(6'h3f, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      v = 16'($urandom);
      wr(6'(i), v);
      rchk(6'(i), {4'h0, v[11:0]});
      chk(16'(i ? gate_setpoint_ch2 : gate_setpoint_ch1), 16'(v[11:0]));
    end
    wr(`BCR_OFS_DACIN1, 16'h0a5c);
    wr(`BCR_OFS_DACIN2, 16'h03e7);
    chk(16'(dac_out_ch1), 16'h0000);
    wr(`BCR_OFS_LOAD_DAC_STROBE, {14'($urandom), 2'h1});
    chk(16'(dac_out_ch1), 16'h0a5c);
    chk(16'(dac_out_ch2), 16'h0000);
    wr(`BCR_OFS_LOAD_DAC_STROBE, {14'($urandom), 2'h2});
    chk(16'(dac_out_ch2), 16'h03e7);
    wr(`BCR_OFS_DACIN1, 16'h0111);
    cyc(2);
    chk(16'(dac_out_ch1), 16'h0a5c);
    wr(`BCR_OFS_CTRL, 16'h0002);
    chk(16'(chan_dac_powerdown), 16'h0001);
    wr(`BCR_OFS_DACIO1, 16'h0777);
    chk(16'(dac_out_ch1), 16'h0777);
    for (int s = 0; s < 4; s++)
    begin
      v = s == 3 ? 16'hffff : s == 2 ? 16'h0000 : 16'($urandom);
      wr(`BCR_OFS_CTRL, 16'(s) << 3);
      // No compensation is modelled, so its enables stay cleared here.
      wr(`BCR_OFS_PARAM, v);
      g = s > 1 ? 16'hf0ff : 16'hffff;
      rchk(`BCR_OFS_PARAM, v & g);
      chk(16'(temp_hyst_lsb), 16'(v[15:12]) + 16'h1);
      if (s > 1)
        chk(16'(param_hyst_lsb), 16'(v[3:0]) + 16'h1);
    end
    wr(`BCR_OFS_CTRL, 16'h0010);
    for (int k = 0; k < 8; k++)
    begin
      v = {8'h00, 1'(k), 3'(k), 4'h0};
      wr(`BCR_OFS_PARAM, v);
      @(negedge ref_clk);
      avg_in_valid = 1'b1;
      avg_in_ch = 1'($urandom);
      avg_in_data = 12'($urandom);
      @(negedge ref_clk);
      avg_in_valid = 1'b0;
      av[avg_in_ch] = nxt(av[avg_in_ch], avg_in_data, v[7], v[6:4]);
      cyc(3);
      g = 16'(avg_in_ch ? param_avg_ch2 : param_avg_ch1);
      chk(g, 16'(av[avg_in_ch]));
    end
    wr(`BCR_OFS_MODE, 16'h0002);
    for (int k = 0; k < 10; k++)
    begin
      q[k] = 16'($urandom);
      pulse_mon(q[k]);
    end
    for (int k = 3; k < 10; k++)
      rchk(`BCR_OFS_FIFO, q[k]);
    rchk(`BCR_OFS_FIFO, 16'h0000);
    wr(`BCR_OFS_CTRL, 16'h0001);
    chk(16'(osc_run), 16'h0000);
    pulse_mon(16'h1234);
    wr(`BCR_OFS_SETPT1, 16'h0abc);
    chk(16'(osc_run), 16'h0001);
    rchk(`BCR_OFS_FIFO, 16'h0000);
    msg(8'hfc, 8'h09);
    msg(8'h10, 8'h00);
    hold = 1'b1;
    wr(`BCR_OFS_MODE, 16'h2003);
    for (int k = 0; k < 9; k++)
    begin
      v = 16'($urandom);
      if (k < 8)
        sh[8'h20 + 8'(k)] = v;
      wr(`BCR_OFS_FIFO, v);
    end
    rchk(`BCR_OFS_FIFO, 16'h0000);
    hold = 1'b0;
    cyc(80);
    msg(8'h20, 8'h08);
    wr(`BCR_OFS_SETPT1, 16'h0123);
    wdog_ovf = 1'b1;
    n = 0;
    while (alarm_pulse !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n < 8), 16'h0001);
    n = 0;
    while (alarm_pulse === 1'b1 && n < 30)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n), 16'(`BCR_ALM_PULSE_CYC));
    wdog_ovf = 1'b0;
    rchk(`BCR_OFS_SETPT1, 16'h0000);
    stop_test();
  end
endmodule : tb
